/* rtl/image_chunk_appender.sv */
// appends frame counter and time stamp chunks to images
`timescale 1ns/1ps
`include "chunk_defines.svh"
module image_chunk_appender (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  // apb slave
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [7:0]    i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic [31:0]        o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  // acquisition trigger, same clock
  input  wire logic          i_frame_begin_event,
  // external clear lines, asynchronous
  input  wire logic          i_input_line_one,
  input  wire logic          i_input_line_two,
  // pixel stream in
  input  wire logic          i_pix_valid,
  input  wire chunk_pkg::word_s i_pix,
  output logic               o_pix_ready,
  // stream to the host link
  output logic               o_out_valid,
  output chunk_pkg::word_s   o_out,
  input  wire logic          i_out_ready,
  output logic               o_payload_kind
);
  import chunk_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic        active_reg;
  logic        sel_reg;
  logic [1:0]  en_reg;
  logic [1:0]  pick_reg;
  logic [1:0]  evt_reg;
  clear_src_e  clr_src_reg;
  logic [31:0] frame_cnt_reg;
  logic [31:0] prdata_reg;
  logic [2:0]  input_line_one_reg;
  logic [2:0]  input_line_two_reg;
  logic [31:0] trig_fc_reg;
  logic [31:0] trig_ts_reg;
  logic [1:0]  trig_en_reg;
  logic [31:0] img_fc_reg;
  logic [31:0] img_ts_reg;
  logic [1:0]  img_en_reg;
  logic        first_reg;
  logic        idx_reg;
  logic        idx_next;
  state_e      state_reg;
  state_e      state_next;
  logic        out_valid_reg;
  word_s       out_reg;
  word_s       out_next;
  logic        out_load;
  logic [31:0] stamp;
  logic        wr_en;
  logic        rd_setup;
  logic        acc_phase;
  logic        hit;
  logic [31:0] rd_mux;
  logic        wr_ctrl;
  logic        wr_en_reg;
  logic        wr_cfg;
  logic        wr_cmd;
  logic        cfg_ready;
  logic        edge1;
  logic        edge2;
  logic        clr_pulse;
  logic        out_free;
  logic        pix_fire;
  logic        pix_end;
  logic        any_en;

  // ****************************************
  // time base
  // ****************************************
  cycle_timer u_timer (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .o_stamp (stamp)
  );

  // ****************************************
  // apb decode
  // ****************************************
  // zero wait states: every access completes at once
  assign acc_phase = i_psel && i_penable;
  assign wr_en     = acc_phase && i_pwrite;
  assign rd_setup  = i_psel && !i_penable && !i_pwrite;
  assign hit       = i_paddr[1:0] == 2'h0 && i_paddr <= `REG_STATUS;
  assign wr_ctrl   = wr_en && i_paddr == `REG_CTRL;
  assign wr_en_reg = wr_en && i_paddr == `REG_CHUNK_EN;
  assign wr_cfg    = wr_en && i_paddr == `REG_CNT_CFG;
  assign wr_cmd    = wr_en && i_paddr == `REG_CNT_CMD
                     && i_pwdata[0];
  assign o_pready  = 1'b1;
  assign o_pslverr = acc_phase && !hit;
  assign o_prdata  = prdata_reg;

  // clear source only taken once counter setup is right
  assign cfg_ready =
    i_pwdata[`CFG_PICK_LSB +: 2] == `PICK_SECOND &&
    i_pwdata[`CFG_EVT_LSB +: 2] == `EVT_FRAME_BEG;

  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `REG_CTRL:      rd_mux = {30'h0, o_payload_kind, active_reg};
      `REG_CHUNK_SEL: rd_mux = {31'h0, sel_reg};
      `REG_CHUNK_EN:  rd_mux = {31'h0, en_reg[sel_reg]};
      `REG_CNT_CFG:   rd_mux = {22'h0, clr_src_reg, 2'h0, evt_reg,
                                2'h0, pick_reg};
      `REG_FRAME_CNT: rd_mux = frame_cnt_reg;
      `REG_TSTAMP:    rd_mux = stamp;
      `REG_STATUS:    rd_mux = {27'h0, state_reg, en_reg};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) prdata_reg <= 32'h0000_0000;
    else if (rd_setup) prdata_reg <= rd_mux;
  end

  // ****************************************
  // chunk mode and enables
  // ****************************************
  assign o_payload_kind = active_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_reg <= 1'b0;
      sel_reg    <= 1'b0;
      en_reg     <= 2'h0;
    end else begin
      if (wr_ctrl) active_reg <= i_pwdata[0];
      if (wr_en && i_paddr == `REG_CHUNK_SEL) sel_reg <= i_pwdata[0];
      if (wr_ctrl && !i_pwdata[0]) en_reg <= 2'h0;
      else if (wr_en_reg && active_reg)
        en_reg[sel_reg] <= i_pwdata[0];
    end
  end

  // ****************************************
  // counter setup and clear sources
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pick_reg    <= 2'h0;
      evt_reg     <= 2'h0;
      clr_src_reg <= CLR_OFF;
    end else if (wr_cfg) begin
      pick_reg <= i_pwdata[`CFG_PICK_LSB +: 2];
      evt_reg  <= i_pwdata[`CFG_EVT_LSB +: 2];
      if (cfg_ready)
        clr_src_reg <= clear_src_e'(i_pwdata[`CFG_CLR_LSB +: 2]);
    end
  end

  // two flops to synchronise, a third for the edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      input_line_one_reg <= 3'h0;
      input_line_two_reg <= 3'h0;
    end else begin
      input_line_one_reg <= {input_line_one_reg[1:0], i_input_line_one};
      input_line_two_reg <= {input_line_two_reg[1:0], i_input_line_two};
    end
  end

  // only stage 1 and 2 are looked at, never stage 0
  assign edge1 = input_line_one_reg[1] && !input_line_one_reg[2];
  assign edge2 = input_line_two_reg[1] && !input_line_two_reg[2];

  // one clear per event from the chosen source
  always_comb begin
    case (clr_src_reg)
      CLR_INPUT_LINE_ONE: clr_pulse = edge1;
      CLR_INPUT_LINE_TWO: clr_pulse = edge2;
      CLR_SOFT:  clr_pulse = wr_cmd;
      default:   clr_pulse = 1'b0;
    endcase
  end

  // ****************************************
  // frame counter and trigger snapshot
  // ****************************************
  // clear beats a count in the same cycle so the
  // next image is numbered zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) frame_cnt_reg <= 32'h0000_0000;
    else if (clr_pulse) frame_cnt_reg <= 32'h0000_0000;
    else if (i_frame_begin_event)
      frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
  end

  // values for the image that this trigger starts
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_fc_reg <= 32'h0000_0000;
      trig_ts_reg <= 32'h0000_0000;
      trig_en_reg <= 2'h0;
    end else if (i_frame_begin_event) begin
      trig_fc_reg <= clr_pulse ? 32'h0000_0000 : frame_cnt_reg;
      trig_ts_reg <= stamp;
      trig_en_reg <= en_reg;
    end
  end

  // snapshot moves to the image at its first pixel;
  // a new trigger may come while chunks still drain
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      img_fc_reg <= 32'h0000_0000;
      img_ts_reg <= 32'h0000_0000;
      img_en_reg <= 2'h0;
      first_reg  <= 1'b1;
    end else if (pix_fire) begin
      first_reg <= i_pix.last;
      if (first_reg) begin
        img_fc_reg <= trig_fc_reg;
        img_ts_reg <= trig_ts_reg;
        img_en_reg <= trig_en_reg;
      end
    end
  end

  // ****************************************
  // output stream
  // ****************************************
  // chunk enables of the image being sent
  assign any_en   = first_reg ? |trig_en_reg : |img_en_reg;
  assign out_free = !out_valid_reg || i_out_ready;
  assign o_pix_ready = out_free && state_reg == S_PIX;
  assign pix_fire = i_pix_valid && o_pix_ready;
  assign pix_end  = pix_fire && i_pix.last;
  assign o_out_valid = out_valid_reg;
  assign o_out    = out_reg;

  // chunk word: tag first, then its value
  function automatic logic [31:0] chunk_word(
    input logic        kind,
    input logic        is_tag,
    input logic [31:0] fc,
    input logic [31:0] ts
  );
    logic [31:0] tag;
    tag = kind ? `TAG_TSTAMP : `TAG_FRAME_CNT;
    chunk_word = is_tag ? tag : (kind ? ts : fc);
  endfunction

  // sequencer: pixels, then frame counter, then stamp
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    out_load   = 1'b0;
    out_next   = out_reg;
    case (state_reg)
      S_PIX: begin
        if (pix_fire) begin
          out_load = 1'b1;
          out_next.data = i_pix.data;
          out_next.last = i_pix.last && !any_en;
          if (pix_end && any_en) begin
            state_next = S_TAG;
            idx_next = first_reg ? !trig_en_reg[0] : !img_en_reg[0];
          end
        end
      end
      S_TAG: begin
        if (out_free) begin
          out_load = 1'b1;
          out_next.data = chunk_word(idx_reg, 1'b1,
                                     img_fc_reg, img_ts_reg);
          out_next.last = 1'b0;
          state_next = S_VAL;
        end
      end
      S_VAL: begin
        if (out_free) begin
          out_load = 1'b1;
          out_next.data = chunk_word(idx_reg, 1'b0,
                                     img_fc_reg, img_ts_reg);
          out_next.last = idx_reg || !img_en_reg[1];
          if (!idx_reg && img_en_reg[1]) begin
            state_next = S_TAG;
            idx_next = 1'b1;
          end else begin
            state_next = S_PIX;
          end
        end
      end
      default: begin
        state_next = S_PIX;
      end
    endcase
  end

  // state and output stage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg     <= S_PIX;
      idx_reg       <= 1'b0;
      out_valid_reg <= 1'b0;
      out_reg       <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      if (out_load) out_reg <= out_next;
      if (out_free) out_valid_reg <= out_load;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_enable_needs_mode: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !active_reg |-> en_reg == 2'h0)
    else $error("chunk enabled while append mode off");

  a_mode_off_clears: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_ctrl && !i_pwdata[0] |=> en_reg == 2'h0 && !o_payload_kind)
    else $error("mode off left a chunk enabled");

  a_count_step: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_frame_begin_event && !clr_pulse
    |=> frame_cnt_reg == $past(frame_cnt_reg) + 32'h0000_0001)
    else $error("frame counter did not step by one");

  a_clear_off_none: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    clr_src_reg == CLR_OFF && !i_frame_begin_event
    |=> $stable(frame_cnt_reg))
    else $error("frame counter moved with clear off");

  a_soft_clear: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_cmd && clr_src_reg == CLR_SOFT |=> frame_cnt_reg == 32'h0)
    else $error("software clear missed");

  a_stamp_latch: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_frame_begin_event |=> trig_ts_reg == $past(stamp))
    else $error("time stamp not latched at trigger");

  a_tag_then_value: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    state_reg == S_TAG && out_free
    |=> state_reg == S_VAL && out_valid_reg && !out_reg.last)
    else $error("chunk tag not followed by its value");

endmodule

/* rtl/chunk_defines.svh */
// constants for the image chunk appender
// Operation
// - chunk enable refused while append mode off
// - append mode off clears every chunk enable
// - append mode switches payload kind to chunks
// - enabled chunks trail the image pixels
// - 32-bit frame counter from zero, step one
// - frame counter wraps to zero after maximum
// - stopped capture may skip counter values
// - frame counter chunk on every image
// - power cycle clears frame counter
// - clear source line one, two, software, off
// - clear source off after power-up
// - software clear command clears counter
// - second counter, frame begin source first
// - trigger count leads frame count by one
// - both counters restart at zero after wrap
// - time stamp latched at acquisition trigger
// - cycle timers restart at every reset
// - bits 0-6 seconds, wrap after 127
// - bits 7-19 bus cycles, wrap after 7999
// - bits 20-31 offset, wrap after 3071
// - time stamp chunk on every image
`ifndef CHUNK_DEFINES_SVH
`define CHUNK_DEFINES_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define REG_CTRL      8'h00
`define REG_CHUNK_SEL 8'h04
`define REG_CHUNK_EN  8'h08
`define REG_CNT_CFG   8'h0C
`define REG_CNT_CMD   8'h10
`define REG_FRAME_CNT 8'h14
`define REG_TSTAMP    8'h18
`define REG_STATUS    8'h1C

// ****************************************
// field positions and codes
// ****************************************
`define CFG_PICK_LSB  0
`define CFG_EVT_LSB   4
`define CFG_CLR_LSB   8
`define PICK_SECOND   2'h2
`define EVT_FRAME_BEG 2'h1
`define TAG_FRAME_CNT 32'hC4A1_0001
`define TAG_TSTAMP    32'hC4A1_0002

// ****************************************
// time stamp timing
// ****************************************
`define MCLK_KHZ      100000
`define OFFSET_KHZ    24576
`define OFFSET_MAX    12'hBFF
`define CYCLE_MAX     13'h1F3F

`endif

/* rtl/chunk_pkg.sv */
// types shared by the chunk appender files
package chunk_pkg;

  // one stream word with its end marker
  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } word_s;

  typedef enum logic [1:0] {
    CLR_OFF  = 2'h0,
    CLR_INPUT_LINE_ONE = 2'h1,
    CLR_INPUT_LINE_TWO = 2'h2,
    CLR_SOFT = 2'h3
  } clear_src_e;

  typedef enum logic [2:0] {
    S_PIX = 3'b001,
    S_TAG = 3'b010,
    S_VAL = 3'b100
  } state_e;

endpackage

/* rtl/cycle_timer.sv */
// bus cycle timer that forms the 32-bit time stamp
`timescale 1ns/1ps
`include "chunk_defines.svh"
module cycle_timer (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  output logic [31:0]      o_stamp
);
  // ****************************************
  // fractional 24.576 MHz tick
  // ****************************************
  logic [16:0] acc_reg;
  logic [11:0] off_reg;
  logic [12:0] cyc_reg;
  logic [6:0]  sec_reg;
  logic [17:0] acc_sum;
  logic        tick;
  logic        off_wrap;
  logic        cyc_wrap;

  // phase accumulator avoids a second clock domain
  assign acc_sum  = {1'b0, acc_reg} + 18'(`OFFSET_KHZ);
  assign tick     = acc_sum >= 18'(`MCLK_KHZ);
  assign off_wrap = tick && off_reg == `OFFSET_MAX;
  assign cyc_wrap = off_wrap && cyc_reg == `CYCLE_MAX;
  assign o_stamp  = {off_reg, cyc_reg, sec_reg};

  // counters restart only at reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= 17'h0_0000;
      off_reg <= 12'h000;
      cyc_reg <= 13'h0000;
      sec_reg <= 7'h00;
    end else begin
      acc_reg <= tick ? 17'(acc_sum - 18'(`MCLK_KHZ))
                      : acc_sum[16:0];
      if (tick) off_reg <= off_wrap ? 12'h000 : off_reg + 12'h001;
      if (off_wrap) cyc_reg <= cyc_wrap ? 13'h0000 : cyc_reg + 13'h0001;
      if (cyc_wrap) sec_reg <= sec_reg + 7'h01;
    end
  end

  a_offset_wrap: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    off_wrap |=> off_reg == 12'h000 && cyc_reg != $past(cyc_reg))
    else $error("cycle offset did not wrap into cycle count");

  a_cycle_wrap: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    cyc_wrap |=> cyc_reg == 13'h0000 && sec_reg == $past(sec_reg) + 7'h01)
    else $error("cycle count did not wrap into seconds");

endmodule

/* verification/host_sink.sv */
// host side model that receives the chunked image stream
`timescale 1ns/1ps
module host_sink (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_stall,
  input  wire logic             i_out_valid,
  input  wire chunk_pkg::word_s i_out,
  output logic                  o_out_ready
);
  import chunk_pkg::*;
  word_s      rx_q[$];
  logic [1:0] phase_reg;

  // refuse one cycle in three so the appender must hold its word
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg   <= 2'h0;
      o_out_ready <= 1'b0;
    end else begin
      phase_reg   <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      o_out_ready <= !(i_stall && phase_reg == 2'h2);
    end
  end

  // keep every word taken; counter values are not checked for gaps here
  always @(posedge i_mclk) begin
    if (i_rst_n && i_out_valid === 1'b1 && o_out_ready) begin
      rx_q.push_back(i_out);
    end
  end
endmodule

/* verification/image_chunk_appender_tb_top.sv */
// self-checking bench for the image chunk appender
`timescale 1ns/1ps
`include "chunk_defines.svh"
module image_chunk_appender_tb_top;
  import chunk_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig = 1'b0;
  logic        line_one = 1'b0;
  logic        line_two = 1'b0;
  logic        pix_valid = 1'b0;
  word_s       pix = '0;
  logic        pix_ready;
  logic        out_valid;
  word_s       out_w;
  logic        out_ready;
  logic        payload_kind;
  logic        stall = 1'b0;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [31:0] fcnt = 32'h0;

  always #5 mclk = ~mclk;

  image_chunk_appender dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_frame_begin_event(trig), .i_input_line_one(line_one),
    .i_input_line_two(line_two), .i_pix_valid(pix_valid), .i_pix(pix),
    .o_pix_ready(pix_ready), .o_out_valid(out_valid), .o_out(out_w),
    .i_out_ready(out_ready), .o_payload_kind(payload_kind)
  );

  host_sink host (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_stall(stall),
    .i_out_valid(out_valid), .i_out(out_w), .o_out_ready(out_ready)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] x);
    logic [31:0] r;
    rd(a, r);
    check({1'b0, r & m}, {1'b0, x});
  endtask

  // stamp as a count of offset ticks
  function automatic longint lin(input logic [31:0] s);
    return longint'(s[31:20]) +
           64'd3072 * (longint'(s[19:7]) + 64'd8000 * longint'(s[6:0]));
  endfunction

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    fcnt = 32'h0;
  endtask

  // one image of n words, then the expected trailing chunks
  task automatic image(input int n, input logic fe, input logic te);
    logic [31:0] t0, t1;
    word_s       e[$];
    int          k;
    host.rx_q.delete();
    rd(`REG_TSTAMP, t0);
    @(posedge mclk); trig <= 1'b1;
    @(posedge mclk); trig <= 1'b0;
    rd(`REG_TSTAMP, t1);
    for (k = 0; k < n; k++) begin
      pix_valid <= 1'b1;
      pix <= '{32'hA000_0000 + k, k == n - 1};
      do @(posedge mclk); while (pix_ready !== 1'b1);
      e.push_back('{32'hA000_0000 + k, (k == n - 1) && !fe && !te});
    end
    pix_valid <= 1'b0;
    if (fe) begin
      e.push_back('{`TAG_FRAME_CNT, 1'b0});
      e.push_back('{fcnt, !te});
    end
    if (te) begin
      e.push_back('{`TAG_TSTAMP, 1'b0});
    end
    k = 0;
    while (host.rx_q.size() < e.size() + te && k < 200) begin
      @(posedge mclk); k++;
    end
    check(33'(host.rx_q.size()), 33'(e.size() + te));
    for (k = 0; k < e.size() && k < host.rx_q.size(); k++) begin
      check(host.rx_q[k], e[k]);
    end
    if (te && host.rx_q.size() > e.size()) begin
      check(33'(host.rx_q[e.size()].last), 33'h1);
      k = lin(host.rx_q[e.size()].data) >= lin(t0) &&
          lin(host.rx_q[e.size()].data) <= lin(t1);
      check(33'(k), 33'h1);
    end
    fcnt = fcnt + 32'h1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] s;
    check(33'(payload_kind), 33'h0);
    rd_chk(`REG_FRAME_CNT, 32'hFFFF_FFFF, 32'h0);
    rd_chk(`REG_CNT_CFG, 32'h0000_0300, 32'h0);
    rd_chk(`REG_STATUS, 32'h3, 32'h0);
    rd(`REG_TSTAMP, s);
    check(33'(lin(s) < 64'd40), 33'h1);
  endtask

  task automatic t_refuse();
    logic [31:0] r;
    logic        e;
    wr(`REG_CHUNK_SEL, 32'h0);
    wr(`REG_CHUNK_EN, 32'h1);
    rd_chk(`REG_STATUS, 32'h3, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check({1'b0, r}, 33'h0);
    check(33'(e), 33'h1);
  endtask

  task automatic t_chunks();
    wr(`REG_CTRL, 32'h1);
    @(posedge mclk);
    check(33'(payload_kind), 33'h1);
    wr(`REG_CHUNK_SEL, 32'h0);
    wr(`REG_CHUNK_EN, 32'h1);
    wr(`REG_CHUNK_SEL, 32'h1);
    wr(`REG_CHUNK_EN, 32'h1);
    rd_chk(`REG_STATUS, 32'h3, 32'h3);
    stall <= 1'b1;
    image(3, 1'b1, 1'b1);
    image(1, 1'b1, 1'b1);
    wr(`REG_CHUNK_SEL, 32'h0);
    wr(`REG_CHUNK_EN, 32'h0);
    image(2, 1'b0, 1'b1);
    wr(`REG_CHUNK_EN, 32'h1);
    wr(`REG_CHUNK_SEL, 32'h1);
    wr(`REG_CHUNK_EN, 32'h0);
    image(1, 1'b1, 1'b0);
    stall <= 1'b0;
  endtask

  // one bus cycle of 125 us is 3072 offset ticks
  task automatic t_stamp();
    logic [31:0] t0, t1;
    rd(`REG_TSTAMP, t0);
    repeat (12500) @(posedge mclk);
    rd(`REG_TSTAMP, t1);
    check(33'(lin(t1) - lin(t0) inside {[3068:3080]}), 33'h1);
  endtask

  task automatic line_pulse(input logic one);
    if (one) line_one <= 1'b1; else line_two <= 1'b1;
    repeat (5) @(posedge mclk);
    line_one <= 1'b0;
    line_two <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic t_clear();
    wr(`REG_CNT_CFG, 32'h0000_0311);
    rd_chk(`REG_CNT_CFG, 32'h0000_0300, 32'h0);
    wr(`REG_CNT_CFG, 32'h0000_0312);
    wr(`REG_CNT_CMD, 32'h1);
    fcnt = 32'h0;
    rd_chk(`REG_FRAME_CNT, 32'hFFFF_FFFF, fcnt);
    image(1, 1'b1, 1'b0);
    wr(`REG_CNT_CFG, 32'h0000_0112);
    line_pulse(1'b0);
    rd_chk(`REG_FRAME_CNT, 32'hFFFF_FFFF, fcnt);
    line_pulse(1'b1);
    fcnt = 32'h0;
    rd_chk(`REG_FRAME_CNT, 32'hFFFF_FFFF, fcnt);
    image(1, 1'b1, 1'b0);
    wr(`REG_CNT_CFG, 32'h0000_0212);
    line_pulse(1'b1);
    rd_chk(`REG_FRAME_CNT, 32'hFFFF_FFFF, fcnt);
    line_pulse(1'b0);
    fcnt = 32'h0;
    rd_chk(`REG_FRAME_CNT, 32'hFFFF_FFFF, fcnt);
    image(1, 1'b1, 1'b0);
    wr(`REG_CNT_CFG, 32'h0000_0012);
    line_pulse(1'b1);
    line_pulse(1'b0);
    wr(`REG_CNT_CMD, 32'h1);
    rd_chk(`REG_FRAME_CNT, 32'hFFFF_FFFF, fcnt);
  endtask

  task automatic t_off();
    wr(`REG_CTRL, 32'h0);
    @(posedge mclk);
    check(33'(payload_kind), 33'h0);
    rd_chk(`REG_STATUS, 32'h3, 32'h0);
    image(2, 1'b0, 1'b0);
  endtask

  // hang guard; whole run needs about 13000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    do_reset();
    t_reset();
    t_refuse();
    t_chunks();
    t_stamp();
    t_clear();
    t_off();
    do_reset();
    t_reset();
    summarize();
  end
endmodule
